/* File: shared/acp_pkg.sv */
package acp_pkg;

  // ****************************************************************
  // Port geometry and comparator bit positions.
  // ****************************************************************
  localparam int unsigned PORT_WIDTH  = 5;
  localparam int unsigned ADDR_WIDTH  = 8;
  localparam int unsigned DATA_WIDTH  = 8;
  localparam int unsigned REF_BIT     = 3;
  localparam int unsigned SIG_BIT     = 4;
  localparam int unsigned SYNC_STAGES = 2;

  // ****************************************************************
  // Register addresses on the register port.
  // ****************************************************************
  localparam logic [7:0] SFR_ADDR    = 8'hd7;
  localparam logic [7:0] DIR_ADDR    = 8'hd6;
  localparam logic [7:0] OUT_ADDR    = 8'hd5;
  localparam logic [7:0] IN_ADDR     = 8'hd4;
  localparam logic [7:0] STATUS_ADDR = 8'he0;
  localparam logic [7:0] MASK_ADDR   = 8'he1;

  // ****************************************************************
  // Interrupt status and mask field positions.
  // ****************************************************************
  localparam int unsigned IRQ_RISE_BIT = 0;
  localparam int unsigned IRQ_FALL_BIT = 1;
  localparam int unsigned IRQ_WIDTH    = 2;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [4:0] SFR_RST    = 5'h00;
  localparam logic [4:0] DIR_RST    = 5'h00;
  localparam logic [4:0] OUT_RST    = 5'h00;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST   = 2'h0;
  localparam logic [7:0] RDATA_RST  = 8'h00;

endpackage

/* File: hdl/acp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-stage synchroniser, one lane per bit.
// ****************************************************************
module acp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  if (WIDTH < 1) begin : g_chk
    $error("acp_sync needs at least one lane.");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule

`default_nettype wire

/* File: hdl/acp_edge.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Edge detector on an already synchronised level.
// ****************************************************************
module acp_edge (
  input  wire logic mclk_in,
  input  wire logic srst_in,
  input  wire logic enable_in,
  input  wire logic level_in,
  output logic      rise_out,
  output logic      fall_out
);

  logic last_q;

  // Tracks the level so that a change shows as a one-cycle pulse.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      last_q <= 1'b0;
    end else begin
      last_q <= level_in;
    end
  end

  // Edges are suppressed while the source is not enabled.
  assign rise_out = enable_in & level_in & ~last_q;
  assign fall_out = enable_in & ~level_in & last_q;

endmodule

`default_nettype wire

/* File: hdl/acp_top.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The comparator runs only while special-function bits 3 and 4 are both set.
// - With the comparator on, input-value bit 4 shows the synchronised comparator result.
// - With the comparator on, input-value bit 3 keeps a synchronised reference pin sample.
// - With the comparator on, signal pin interrupts come from the comparator result.
// - The result reads one when the signal is above the reference and zero below it.
// - Comparator and synchroniser keep working during clock-idle mode.
// - An enabled comparator interrupt during clock-idle mode wakes the core.
// - In full shutdown the comparator is powered down and yields no result or interrupt.
// - Every input sample passes two flip-flops before the input-value register.
// - Full reset clears every special-function bit, switching the comparator off.
module acp_top #(
  parameter int unsigned PORT_W = acp_pkg::PORT_WIDTH
) (
  input  wire logic                               mclk_in,
  input  wire logic                               srst_in,
  input  wire logic [acp_pkg::ADDR_WIDTH-1:0]     reg_addr_in,
  input  wire logic [acp_pkg::DATA_WIDTH-1:0]     reg_wdata_in,
  input  wire logic                               reg_wr_in,
  input  wire logic                               reg_rd_in,
  output logic      [acp_pkg::DATA_WIDTH-1:0]     reg_rdata_out,
  input  wire logic [PORT_W-1:0]                  port_pin_in,
  output logic      [PORT_W-1:0]                  port_pin_out,
  output logic      [PORT_W-1:0]                  port_pin_oe_out,
  input  wire logic                               cmp_raw_in,
  output logic                                    cmp_power_en_out,
  input  wire logic                               halt_mode_in,
  input  wire logic                               stop_mode_in,
  output logic                                    irq_out,
  output logic                                    wake_out
);
  import acp_pkg::*;

  // ****************************************************************
  // Elaboration check.
  // ****************************************************************
  if (PORT_W != PORT_WIDTH) begin : g_chk
    $error("acp_top serves a five-bit port only.");
  end

  // ****************************************************************
  // Registers and named wires.
  // ****************************************************************
  logic [PORT_W-1:0]     sfr_q;
  logic [PORT_W-1:0]     dir_q;
  logic [PORT_W-1:0]     out_q;
  logic [PORT_W-1:0]     in_q;
  logic [PORT_W-1:0]     in_d;
  logic [IRQ_WIDTH-1:0]  status_q;
  logic [IRQ_WIDTH-1:0]  status_d;
  logic [IRQ_WIDTH-1:0]  mask_q;
  logic [DATA_WIDTH-1:0] rdata_q;
  logic [DATA_WIDTH-1:0] rdata_d;
  logic [PORT_W-1:0]     pin_sync;
  logic                  cmp_sync;
  logic                  cmp_sel;
  logic                  cmp_act;
  logic                  irq_src;
  logic                  src_rise;
  logic                  src_fall;
  logic [IRQ_WIDTH-1:0]  events;
  logic                  sfr_wr;
  logic                  dir_wr;
  logic                  out_wr;
  logic                  in_wr;
  logic                  status_wr;
  logic                  mask_wr;
  logic [PORT_W-1:0]     sample;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  assign sfr_wr    = reg_wr_in && (reg_addr_in == SFR_ADDR);
  assign dir_wr    = reg_wr_in && (reg_addr_in == DIR_ADDR);
  assign out_wr    = reg_wr_in && (reg_addr_in == OUT_ADDR);
  assign in_wr     = reg_wr_in && (reg_addr_in == IN_ADDR);
  assign status_wr = reg_wr_in && (reg_addr_in == STATUS_ADDR);
  assign mask_wr   = reg_wr_in && (reg_addr_in == MASK_ADDR);

  // ****************************************************************
  // Comparator enable and power.
  // ****************************************************************
  // Both special-function bits select the comparator; shutdown overrides it.
  assign cmp_sel          = sfr_q[REF_BIT] & sfr_q[SIG_BIT];
  assign cmp_act          = cmp_sel & ~stop_mode_in;
  assign cmp_power_en_out = cmp_act;

  // ****************************************************************
  // Synchronisers for the pins and the comparator result.
  // ****************************************************************
  // Pin samples pass two flip-flops before they reach the input register.
  acp_sync #(
    .WIDTH    (PORT_W)
  ) u_pin_sync (
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .async_in (port_pin_in),
    .sync_out (pin_sync)
  );

  // The comparator result high means signal above reference.
  acp_sync #(
    .WIDTH    (1)
  ) u_cmp_sync (
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .async_in (cmp_raw_in & cmp_act),
    .sync_out (cmp_sync)
  );

  // ****************************************************************
  // Input value register.
  // ****************************************************************
  // Bit 4 takes the comparator result while the comparator is selected.
  assign sample = cmp_sel ? {cmp_sync, pin_sync[REF_BIT:0]} : pin_sync;

  // Input bits refresh every cycle; output bits keep what software wrote.
  // In shutdown the comparator bit holds, as no result is produced.
  for (genvar i = 0; i < PORT_W; i++) begin : g_in
    logic hold;
    assign hold = dir_q[i] || (i == SIG_BIT && cmp_sel && stop_mode_in);
    assign in_d[i] = hold ? (in_wr ? reg_wdata_in[i] : in_q[i]) : sample[i];
  end

  // ****************************************************************
  // Interrupt source and edge detection.
  // ****************************************************************
  // The signal pin interrupt follows the comparator while it is selected.
  assign irq_src = cmp_sel ? cmp_sync : pin_sync[SIG_BIT];

  acp_edge u_edge (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .enable_in (~(cmp_sel & stop_mode_in)),
    .level_in  (irq_src),
    .rise_out  (src_rise),
    .fall_out  (src_fall)
  );

  assign events = {src_fall, src_rise};

  // Sticky status: a new event wins over a write-one clear.
  assign status_d = (status_q & ~(status_wr ? reg_wdata_in[IRQ_WIDTH-1:0] : '0)) | events;

  // ****************************************************************
  // Interrupt and wake outputs.
  // ****************************************************************
  assign irq_out  = |(status_q & mask_q);
  assign wake_out = halt_mode_in & irq_out;

  // ****************************************************************
  // Read data selection.
  // ****************************************************************
  always_comb begin
    rdata_d = RDATA_RST;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        SFR_ADDR:    rdata_d = {3'h0, sfr_q};
        DIR_ADDR:    rdata_d = {3'h0, dir_q};
        OUT_ADDR:    rdata_d = {3'h0, out_q};
        IN_ADDR:     rdata_d = {3'h0, in_q};
        STATUS_ADDR: rdata_d = {6'h00, status_q};
        MASK_ADDR:   rdata_d = {6'h00, mask_q};
        default:     rdata_d = RDATA_RST;
      endcase
    end
  end

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  // Full reset clears the special-function and direction bits.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sfr_q <= SFR_RST;
      dir_q <= DIR_RST;
      out_q <= OUT_RST;
    end else begin
      if (sfr_wr) sfr_q <= reg_wdata_in[PORT_W-1:0];
      if (dir_wr) dir_q <= reg_wdata_in[PORT_W-1:0];
      if (out_wr) out_q <= reg_wdata_in[PORT_W-1:0];
    end
  end

  // Input register: reset clears every bit to zero.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      in_q <= '0;
    end else begin
      in_q <= in_d;
    end
  end

  // Interrupt status, mask and read data.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      status_q <= STATUS_RST;
      mask_q   <= MASK_RST;
      rdata_q  <= RDATA_RST;
    end else begin
      status_q <= status_d;
      if (mask_wr) mask_q <= reg_wdata_in[IRQ_WIDTH-1:0];
      rdata_q  <= rdata_d;
    end
  end

  // ****************************************************************
  // Pin drivers.
  // ****************************************************************
  assign port_pin_out    = out_q;
  assign port_pin_oe_out = dir_q;
  assign reg_rdata_out   = rdata_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  logic past_valid_q;

  // Marks the first cycle after reset so that past values are trusted.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      past_valid_q <= 1'b0;
    end else begin
      past_valid_q <= 1'b1;
    end
  end

  // Power follows both select bits and the shutdown input.
  cmp_enable_a: assert property (
    (sfr_q[REF_BIT] && sfr_q[SIG_BIT] && !stop_mode_in) == cmp_power_en_out
  ) else $error("Comparator power does not follow its select bits.");

  // Bit 4 carries the synchronised comparator result.
  sig_bit_a: assert property (
    past_valid_q && $past(cmp_act) && !$past(dir_q[SIG_BIT])
      |-> in_q[SIG_BIT] == $past(cmp_sync)
  ) else $error("Input bit 4 does not show the comparator result.");

  // Bit 3 keeps sampling the reference pin.
  ref_bit_a: assert property (
    past_valid_q && $past(cmp_sel) && !$past(dir_q[REF_BIT])
      |-> in_q[REF_BIT] == $past(pin_sync[REF_BIT])
  ) else $error("Input bit 3 lost the reference sample.");

  // A comparator rise becomes a sticky status bit one cycle later.
  irq_src_a: assert property (
    cmp_act && cmp_sync && !$past(cmp_sync) && past_valid_q
      |=> status_q[IRQ_RISE_BIT]
  ) else $error("Comparator edge did not set the status bit.");

  // A steady high result reads as one after three edges.
  polarity_a: assert property (
    (cmp_act && cmp_raw_in && !dir_q[SIG_BIT])[*4] |-> in_q[SIG_BIT]
  ) else $error("Comparator high did not read as one.");

  // Clock-idle mode does not stop the comparator path.
  halt_run_a: assert property (
    halt_mode_in && cmp_act && cmp_raw_in ##1 cmp_act [*2] |-> cmp_sync
  ) else $error("Comparator stalled during clock-idle mode.");

  // An unmasked comparator event wakes the core in clock-idle mode.
  wake_a: assert property (
    halt_mode_in && cmp_act && src_rise && mask_q[IRQ_RISE_BIT]
      ##1 halt_mode_in |-> wake_out
  ) else $error("Comparator interrupt did not wake the core.");

  // Shutdown powers the comparator down and gives no events.
  stop_off_a: assert property (
    stop_mode_in && cmp_sel |-> !cmp_power_en_out && !src_rise && !src_fall
  ) else $error("Comparator active during shutdown.");

  // Pin bit 0 reaches the input register three edges after the pin.
  sync_depth_a: assert property (
    past_valid_q && $past(past_valid_q, 3) && !$past(dir_q[0])
      |-> in_q[0] == $past(port_pin_in[0], 3)
  ) else $error("Pin sample did not pass two synchroniser stages.");

  // Reset leaves the special-function and direction bits clear.
  reset_clear_a: assert property (
    past_valid_q && $past(past_valid_q) == 1'b0 |-> sfr_q == SFR_RST && dir_q == DIR_RST
  ) else $error("Reset did not clear the special-function bits.");

  // With the comparator off, bit 4 is the plain pin sample.
  plain_bit_a: assert property (
    past_valid_q && !$past(cmp_sel) && !$past(dir_q[SIG_BIT])
      |-> in_q[SIG_BIT] == $past(pin_sync[SIG_BIT])
  ) else $error("Input bit 4 is not the pin sample.");

  // Comparator interrupt reaches the output.
  irq_cover_c: cover property (cmp_act && src_rise ##1 irq_out);

  // Wake from clock-idle mode.
  wake_cover_c: cover property (halt_mode_in && wake_out);

  // Shutdown while the comparator is selected.
  stop_cover_c: cover property (cmp_sel && stop_mode_in);

endmodule

`default_nettype wire

/* File: bench/acp_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Analog front end: signal and reference voltages into one result.
// ****************************************************************
module acp_analog_model (
  input  wire logic mclk_in,
  input  wire logic power_en_in,
  input  var  int   sig_mv_in,
  input  var  int   ref_mv_in,
  output logic      cmp_out
);
  logic idle_q = 1'b0;

  // Unpowered output is meaningless, so it changes every cycle.
  always_ff @(posedge mclk_in) begin
    idle_q <= ~idle_q;
  end

  // High when the signal is above the reference, only while powered.
  assign cmp_out = power_en_in ? (sig_mv_in > ref_mv_in) : idle_q;
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import acp_pkg::*;

  // ****************************************************************
  // Stimulus, observation and bookkeeping.
  // ****************************************************************
  logic       mclk_in = 1'b0;
  logic       srst_in = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [4:0] pin_in = 5'h00;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic       cmp_raw;
  logic       cmp_pwr;
  logic       halt = 1'b0;
  logic       stop = 1'b0;
  logic       irq;
  logic       wake;
  int         sig_mv = 100;
  int         ref_mv = 500;
  int         n_errors = 0;
  int         comparisons = 0;
  int         cycles = 0;

  acp_top i_acp_top (.mclk_in(mclk_in), .srst_in(srst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .port_pin_in(pin_in), .port_pin_out(pin_out),
    .port_pin_oe_out(pin_oe), .cmp_raw_in(cmp_raw), .cmp_power_en_out(cmp_pwr),
    .halt_mode_in(halt), .stop_mode_in(stop), .irq_out(irq), .wake_out(wake));

  acp_analog_model i_acp_analog_model (.mclk_in(mclk_in), .power_en_in(cmp_pwr),
    .sig_mv_in(sig_mv), .ref_mv_in(ref_mv), .cmp_out(cmp_raw));

  // A 25 ns clock.
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Cuts a hang short well beyond the length of the whole sequence.
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_in);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk_in);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic chk_rd(string name, logic [7:0] a, logic [7:0] exp);
    @(posedge mclk_in);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk_in);
    reg_rd   <= 1'b0;
    #1;
    chk(name, reg_rdata, exp);
  endtask

  task automatic set_pins(logic [4:0] p, int sig);
    @(posedge mclk_in);
    pin_in <= p;
    sig_mv <= sig;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset_values();
    chk_rd("sfr", SFR_ADDR, 8'h00);
    chk_rd("dir", DIR_ADDR, 8'h00);
    chk_rd("out", OUT_ADDR, 8'h00);
    chk_rd("in", IN_ADDR, 8'h00);
    chk_rd("status", STATUS_ADDR, 8'h00);
    chk_rd("mask", MASK_ADDR, 8'h00);
    chk_rd("unmapped", 8'h00, 8'h00);
    chk("power", {7'h00, cmp_pwr}, 8'h00);
  endtask

  task automatic t_plain_pins();
    set_pins(5'h18, 900);
    chk_rd("in early", IN_ADDR, 8'h00);
    chk_rd("in late", IN_ADDR, 8'h18);
    wr(DIR_ADDR, 8'h03);
    wr(OUT_ADDR, 8'h1e);
    chk("pin oe", {3'h0, pin_oe}, 8'h03);
    chk("pin out", {3'h0, pin_out}, 8'h1e);
    wr(DIR_ADDR, 8'h00);
    set_pins(5'h07, 100);
    idle(5);
    chk_rd("in plain", IN_ADDR, 8'h07);
  endtask

  task automatic t_compare();
    set_pins(5'h10, 100);
    wr(SFR_ADDR, 8'h10);
    chk("power one bit", {7'h00, cmp_pwr}, 8'h00);
    idle(5);
    chk_rd("in one bit", IN_ADDR, 8'h10);
    wr(SFR_ADDR, 8'h08);
    chk("power other bit", {7'h00, cmp_pwr}, 8'h00);
    wr(SFR_ADDR, 8'h18);
    chk("power both", {7'h00, cmp_pwr}, 8'h01);
    idle(5);
    chk_rd("in below", IN_ADDR, 8'h00);
    set_pins(5'h08, 900);
    idle(5);
    chk_rd("in above", IN_ADDR, 8'h18);
    set_pins(5'h18, 100);
    idle(5);
    chk_rd("in below again", IN_ADDR, 8'h08);
  endtask

  task automatic t_irq();
    set_pins(5'h00, 100);
    wr(MASK_ADDR, 8'h01);
    idle(5);
    wr(STATUS_ADDR, 8'h03);
    chk("irq idle", {7'h00, irq}, 8'h00);
    set_pins(5'h10, 100);
    idle(5);
    chk_rd("pin edge ignored", STATUS_ADDR, 8'h00);
    set_pins(5'h00, 900);
    idle(5);
    chk_rd("rise status", STATUS_ADDR, 8'h01);
    chk("irq rise", {7'h00, irq}, 8'h01);
    wr(STATUS_ADDR, 8'h01);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    set_pins(5'h00, 100);
    idle(5);
    chk_rd("fall status", STATUS_ADDR, 8'h02);
    chk("irq fall masked", {7'h00, irq}, 8'h00);
    wr(MASK_ADDR, 8'h03);
    chk("irq fall", {7'h00, irq}, 8'h01);
    wr(STATUS_ADDR, 8'h03);
  endtask

  task automatic t_halt();
    @(posedge mclk_in);
    halt <= 1'b1;
    set_pins(5'h00, 900);
    idle(5);
    chk("irq halt", {7'h00, irq}, 8'h01);
    chk("wake", {7'h00, wake}, 8'h01);
    chk_rd("in halt", IN_ADDR, 8'h10);
    wr(STATUS_ADDR, 8'h03);
    chk("wake clear", {7'h00, wake}, 8'h00);
    @(posedge mclk_in);
    halt <= 1'b0;
  endtask

  task automatic t_stop();
    @(posedge mclk_in);
    stop <= 1'b1;
    idle(1);
    chk("power stop", {7'h00, cmp_pwr}, 8'h00);
    set_pins(5'h00, 100);
    idle(4);
    set_pins(5'h00, 900);
    idle(6);
    chk_rd("status stop", STATUS_ADDR, 8'h00);
    chk_rd("in stop", IN_ADDR, 8'h10);
    chk("irq stop", {7'h00, irq}, 8'h00);
    @(posedge mclk_in);
    stop <= 1'b0;
    idle(1);
    chk("power after stop", {7'h00, cmp_pwr}, 8'h01);
  endtask

  task automatic t_mid_reset();
    @(posedge mclk_in);
    srst_in <= 1'b1;
    idle(3);
    @(posedge mclk_in);
    srst_in <= 1'b0;
    idle(1);
    chk("power reset", {7'h00, cmp_pwr}, 8'h00);
    chk_rd("sfr reset", SFR_ADDR, 8'h00);
    chk_rd("mask reset", MASK_ADDR, 8'h00);
  endtask

  // Main sequence: reset for six cycles, then every scenario in turn.
  initial begin
    repeat (6) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_reset_values();
    t_plain_pins();
    t_compare();
    t_irq();
    t_halt();
    t_stop();
    t_mid_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
